// ==== dv/adc_output_rate_misc_control_tb.sv ====
// Self-checking bench for the output rate and misc control bank
`timescale 1ns/1ns
`default_nettype none
module adc_output_rate_misc_control_tb;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOe;
	logic [13:0] adcData = 14'h0a5b;
	logic ddcMode = 1'b0;
	logic wordClkIn = 1'b1;
	logic calRequest = 1'b0;
	logic [13:0] dataOut;
	logic dataValid, clkOutP, clkOutN, wordClkOut, calStart;
	logic sdoFall = 1'b1;
	logic [7:0] rd;
	int fails = 0;
	int num_checks = 0;
	int n, m;
	int oeCycles = 0;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (spiSdoOe === 1'b1) oeCycles <= oeCycles + 1;
	end
	rate_misc_ctl #(.DATA_W(14)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .spiCsN(spiCsN),
		.spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
		.adcData(adcData), .ddcMode(ddcMode), .wordClkIn(wordClkIn), .calRequest(calRequest),
		.dataOut(dataOut), .dataValid(dataValid), .clkOutP(clkOutP), .clkOutN(clkOutN),
		.wordClkOut(wordClkOut), .calStart(calStart));
	spi_host_model u_host (.ref_clk(ref_clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
		.spiSdi(spiSdi), .spiSdo(spiSdo));
	////////////////////////////////////////
	task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val
	task automatic chk_cnt(input string nm, input int e, input int g);
		num_checks++;
		if (g != e) begin
			fails++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_cnt
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.frame(1'b0, a[6:0], d, sdoFall, rd);
		if (a == rate_ctl_pkg::OFS_SERIAL_OUT_EDGE_SELECT) sdoFall = d[rate_ctl_pkg::BIT_SDO_EDGE];
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		int o;
		o = oeCycles;
		u_host.frame(1'b1, a[6:0], 8'h00, sdoFall, rd);
		chk_val($sformatf("register %h", a), {8'h00, e}, {8'h00, rd});
		chk_cnt("sdo driven in read", 1, int'(oeCycles > o));
		chk_val("sdo released", 16'h0000, {15'h0000, spiSdoOe});
	endtask : rdchk
	// Cycles between two rises of the clock (sel 0) or the data strobe; bounded
	task automatic period(input int sel, output int cyc);
		logic prev, cur;
		int k;
		cyc = 0;
		prev = 1'b1;
		k = 0;
		for (int i = 0; i < 200 && k < 2; i++) begin
			@(negedge ref_clk);
			cur = (sel == 0) ? clkOutP : dataValid;
			if (k == 1) cyc++;
			if (cur === 1'b1 && prev !== 1'b1) k++;
			prev = cur;
		end
	endtask : period
	task automatic cal_delay(output int cyc);
		calRequest = 1'b1;
		@(negedge ref_clk);
		calRequest = 1'b0;
		cyc = 0;
		while (calStart !== 1'b1 && cyc < 3000) begin
			@(negedge ref_clk);
			cyc++;
		end
	endtask : cal_delay
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		conclude();
	end
	// Test codes 1010..1110 are each written to the clock rate field; factory bits are never altered by these writes
	initial begin
		repeat (3) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		rdchk(rate_ctl_pkg::OFS_DIV_IND, rate_ctl_pkg::RST_DIV_IND);
		rdchk(rate_ctl_pkg::OFS_RATE, rate_ctl_pkg::RST_RATE);
		rdchk(rate_ctl_pkg::OFS_SERIAL_OUT_EDGE_SELECT, rate_ctl_pkg::RST_SERIAL_OUT_EDGE_SELECT);
		rdchk(rate_ctl_pkg::OFS_RAND_WCK, rate_ctl_pkg::RST_RAND_WCK);
		rdchk(rate_ctl_pkg::OFS_CAL_DLY, rate_ctl_pkg::RST_CAL_DLY);
		wr(8'h05, 8'h5a);
		rdchk(8'h05, 8'h00);
		wr(rate_ctl_pkg::OFS_RATE, 8'h23);
		rdchk(rate_ctl_pkg::OFS_RATE, 8'h23);
		period(0, n);
		chk_cnt("clock period shared", 8, n);
		period(1, n);
		chk_cnt("data strobe period", 4, n);
		wr(rate_ctl_pkg::OFS_DIV_IND, rate_ctl_pkg::RST_DIV_IND | 8'h80);
		period(0, n);
		chk_cnt("clock period own", 16, n);
		for (int c = 10; c <= 14; c++) begin
			wr(rate_ctl_pkg::OFS_RATE, {4'h0, c[3:0]});
			n = 0;
			repeat (40) begin
				@(negedge ref_clk);
				if (clkOutP !== 1'b0 || clkOutN !== 1'b0) n++;
			end
			chk_cnt("stopped clock active cycles", 0, n);
		end
		wr(rate_ctl_pkg::OFS_SERIAL_OUT_EDGE_SELECT, 8'h1f);
		rdchk(rate_ctl_pkg::OFS_SERIAL_OUT_EDGE_SELECT, 8'h1f);
		rdchk(rate_ctl_pkg::OFS_RATE, 8'h0e);
		wr(rate_ctl_pkg::OFS_SERIAL_OUT_EDGE_SELECT, 8'h9f);
		rdchk(rate_ctl_pkg::OFS_RATE, 8'h0e);
		wr(rate_ctl_pkg::OFS_RAND_WCK, 8'h63);
		repeat (10) @(negedge ref_clk);
		chk_val("randomized word", {2'b00, adcData[13:1] ^ 13'h1fff, 1'b1}, {2'b00, dataOut});
		ddcMode = 1'b1;
		wr(rate_ctl_pkg::OFS_RAND_WCK, 8'he2);
		repeat (10) @(negedge ref_clk);
		chk_val("plain word", {2'b00, adcData}, {2'b00, dataOut});
		chk_val("word clock inverted", 16'h0000, {15'h0000, wordClkOut});
		ddcMode = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk_val("word clock outside mode", 16'h0001, {15'h0000, wordClkOut});
		wr(rate_ctl_pkg::OFS_CAL_DLY, 8'h02);
		wr(rate_ctl_pkg::OFS_RAND_WCK, 8'h22);
		cal_delay(m);
		chk_cnt("start immediate", 0, m);
		wr(rate_ctl_pkg::OFS_RAND_WCK, 8'h62);
		cal_delay(n);
		chk_cnt("start delay two", 2 * rate_ctl_pkg::CAL_STEP_CYC + 1, n - m);
		wr(rate_ctl_pkg::OFS_CAL_DLY, 8'h03);
		cal_delay(n);
		chk_cnt("start delay three", 3 * rate_ctl_pkg::CAL_STEP_CYC + 1, n - m);
		conclude();
	end
endmodule : adc_output_rate_misc_control_tb
`default_nettype wire

// ==== dv/spi_host_model.sv ====
// Serial host model that frames register reads and writes
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	// Clock
	input wire logic ref_clk,
	// Serial lines
	output logic spiCsN,
	output logic spiSclk,
	output logic spiSdi,
	input wire logic spiSdo
);
	// Six cycles a half period stays clear of the select synchroniser
	localparam int HALF = 6;
	initial begin
		spiCsN = 1'b1;
		spiSclk = 1'b0;
		spiSdi = 1'b0;
	end
	////////////////////////////////////////
	task automatic hold;
		repeat (HALF) @(negedge ref_clk);
	endtask : hold
	// Read bits are taken just before the edge after the one that launched them
	task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
		input logic fallMode, output logic [7:0] rdata);
		logic [15:0] word;
		word = {rd, addr, wd};
		rdata = 8'h00;
		spiCsN = 1'b0;
		for (int i = 0; i <= 16; i++) begin
			if (i < 16) spiSdi = word[15 - i];
			hold();
			if (i >= 8 && i < 16 && fallMode) rdata = {rdata[6:0], spiSdo};
			if (i == 16) break;
			spiSclk = 1'b1;
			hold();
			if (i >= 8 && !fallMode) rdata = {rdata[6:0], spiSdo};
			spiSclk = 1'b0;
		end
		spiCsN = 1'b1;
		// A released line shows the inverse, never a stale bit
		spiSdi = ~spiSdi;
		hold();
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ==== hdl/rate_divider.sv ====
// Output data strobe and output clock divider
`timescale 1ns/1ns
`default_nettype none
module rate_divider (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Settings and results
	rate_div_if.div port
);
	logic [8:0] dataCnt_r;
	logic [8:0] clkCnt_r;
	logic [3:0] clkCode;
	logic [8:0] dataDiv;
	logic [8:0] clkDiv;
	logic clkOff;

	// Dependent mode: output clock follows the data rate code
	assign clkCode = port.indEnable ? port.clkRate : port.dataRate;
	assign clkOff = port.indEnable && (clkCode <= rate_ctl_pkg::CLK_OFF_HI)
		&& (clkCode >= rate_ctl_pkg::CLK_OFF_LO);
	// Code n gives a strobe every 2^n cycles and a clock period of 2^(n+1); codes above 8 act as code 0
	assign dataDiv = (port.dataRate > 4'h8) ? 9'h001 : 9'h001 << port.dataRate;
	assign clkDiv = (clkCode > 4'h8) ? 9'h001 : 9'h001 << clkCode;
	assign port.clkEnable = !clkOff;
	assign port.dataStrobe = (dataCnt_r == 9'h000);
	assign port.clkToggle = (clkCnt_r == 9'h000);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dataCnt_r <= 9'h000;
			clkCnt_r <= 9'h000;
		end else begin
			dataCnt_r <= (dataCnt_r + 9'h001 >= dataDiv) ? 9'h000 : dataCnt_r + 9'h001;
			clkCnt_r <= (clkCnt_r + 9'h001 >= clkDiv) ? 9'h000 : clkCnt_r + 9'h001;
		end
	end
endmodule : rate_divider
`default_nettype wire

// ==== hdl/rate_misc_ctl.sv ====
// Output rate, serial timing, randomizer, word clock and calibration delay control bank
`timescale 1ns/1ns
`default_nettype none
module rate_misc_ctl #(
	parameter int DATA_W = 14
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Serial register port, mode 0 style, MSB first: R/W+7-bit address, 8 data bits
	input wire logic spiCsN,
	input wire logic spiSclk,
	input wire logic spiSdi,
	output logic spiSdo,
	output logic spiSdoOe,
	// Converter data and output clocking
	input wire logic [DATA_W-1:0] adcData,
	input wire logic ddcMode,
	input wire logic wordClkIn,
	input wire logic calRequest,
	output logic [DATA_W-1:0] dataOut,
	output logic dataValid,
	output logic clkOutP,
	output logic clkOutN,
	output logic wordClkOut,
	output logic calStart
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages; select and clock change only when stages two and three agree
	logic [2:0] csSync_r, sclkSync_r, sdiSync_r;
	logic csN_r, sclk_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			csSync_r <= 3'h7;
			sclkSync_r <= 3'h0;
			sdiSync_r <= 3'h0;
			csN_r <= 1'b1;
			sclk_r <= 1'b0;
		end else begin
			csSync_r <= {csSync_r[1:0], spiCsN};
			sclkSync_r <= {sclkSync_r[1:0], spiSclk};
			sdiSync_r <= {sdiSync_r[1:0], spiSdi};
			if (csSync_r[1] == csSync_r[2]) csN_r <= csSync_r[2];
			if (sclkSync_r[1] == sclkSync_r[2]) sclk_r <= sclkSync_r[2];
		end
	end
	wire logic sclkNow = (sclkSync_r[1] == sclkSync_r[2]) ? sclkSync_r[2] : sclk_r;
	wire logic rise = sclkNow && !sclk_r && !csN_r;
	wire logic fall = !sclkNow && sclk_r && !csN_r;

	////////////////////////////////////////////////////////////////////////
	// Serial frame engine
	logic [7:0] shift_r, addr_r, rdata_r;
	logic [4:0] bitCnt_r;
	logic [7:0] regIndRate_r, regRate_r, regSdo_r, regRand_r, regDly_r;
	logic [7:0] rdSel;
	wire logic isRead = addr_r[7];
	wire logic [7:0] addrNxt = {shift_r[6:0], sdiSync_r[2]};
	wire logic [7:0] dataNxt = {shift_r[6:0], sdiSync_r[2]};
	wire logic wrDone = rise && (bitCnt_r == 5'd15) && !isRead;
	wire logic [6:0] regAddr = addr_r[6:0];
	// Read select decodes the address byte as it completes; addr_r loads on that same edge
	wire logic [6:0] rdAddr = addrNxt[6:0];
	assign rdSel = (rdAddr == rate_ctl_pkg::OFS_DIV_IND[6:0]) ? regIndRate_r :
		(rdAddr == rate_ctl_pkg::OFS_RATE[6:0]) ? regRate_r :
		(rdAddr == rate_ctl_pkg::OFS_SERIAL_OUT_EDGE_SELECT[6:0]) ? regSdo_r :
		(rdAddr == rate_ctl_pkg::OFS_RAND_WCK[6:0]) ? regRand_r :
		(rdAddr == rate_ctl_pkg::OFS_CAL_DLY[6:0]) ? regDly_r : 8'h00;
	wire logic sdoEdgeFall = regSdo_r[rate_ctl_pkg::BIT_SDO_EDGE];
	// Read data shifts out on the selected edge
	wire logic sdoShift = sdoEdgeFall ? fall : rise;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_r <= 8'h00;
			addr_r <= 8'h00;
			bitCnt_r <= 5'd0;
		end else if (csN_r) begin
			bitCnt_r <= 5'd0;
		end else if (rise) begin
			shift_r <= dataNxt;
			bitCnt_r <= (bitCnt_r == 5'd15) ? 5'd0 : bitCnt_r + 5'd1;
			if (bitCnt_r == 5'd7) addr_r <= addrNxt;
		end
	end

	// Read data loads after the address byte; out pin held until frame end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 8'h00;
			spiSdo <= 1'b0;
			spiSdoOe <= 1'b0;
		end else if (csN_r) begin
			spiSdoOe <= 1'b0;
		end else if (rise && bitCnt_r == 5'd7 && addrNxt[7]) begin
			rdata_r <= rdSel;
			spiSdo <= 1'b0;
		end else if (sdoShift && isRead && bitCnt_r >= 5'd8) begin
			spiSdo <= rdata_r[7];
			rdata_r <= {rdata_r[6:0], 1'b0};
			spiSdoOe <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register bank, updated on the last clock of a write frame
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regIndRate_r <= rate_ctl_pkg::RST_DIV_IND;
			regRate_r <= rate_ctl_pkg::RST_RATE;
			regSdo_r <= rate_ctl_pkg::RST_SERIAL_OUT_EDGE_SELECT;
			regRand_r <= rate_ctl_pkg::RST_RAND_WCK;
			regDly_r <= rate_ctl_pkg::RST_CAL_DLY;
		end else if (wrDone) begin
			// Factory bits are stored as written; software keeps them at default
			if (regAddr == rate_ctl_pkg::OFS_DIV_IND[6:0]) regIndRate_r <= dataNxt;
			if (regAddr == rate_ctl_pkg::OFS_RATE[6:0]) regRate_r <= dataNxt;
			if (regAddr == rate_ctl_pkg::OFS_SERIAL_OUT_EDGE_SELECT[6:0]) regSdo_r <= dataNxt;
			if (regAddr == rate_ctl_pkg::OFS_RAND_WCK[6:0]) regRand_r <= dataNxt;
			if (regAddr == rate_ctl_pkg::OFS_CAL_DLY[6:0]) regDly_r <= dataNxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Dividers
	rate_div_if divBus ();
	assign divBus.dataRate = regRate_r[7:4];
	assign divBus.clkRate = regRate_r[3:0];
	assign divBus.indEnable = regIndRate_r[rate_ctl_pkg::BIT_IND_EN];
	rate_divider uDiv (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.port(divBus)
	);

	////////////////////////////////////////////////////////////////////////
	// Output path: randomizer XORs bits above bit 0 with bit 0
	logic [DATA_W-1:0] randData;
	wire logic randEn = regRand_r[rate_ctl_pkg::BIT_RAND_EN];
	assign randData = randEn ?
		(adcData ^ {{(DATA_W-1){adcData[0]}}, 1'b0}) : adcData;
	logic clkPh_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dataOut <= '0;
			dataValid <= 1'b0;
			clkPh_r <= 1'b0;
			clkOutP <= 1'b0;
			clkOutN <= 1'b0;
			wordClkOut <= 1'b0;
		end else begin
			dataValid <= divBus.dataStrobe;
			if (divBus.dataStrobe) dataOut <= randData;
			if (divBus.clkToggle) clkPh_r <= !clkPh_r;
			// Both legs low while stopped rather than a stuck differential
			clkOutP <= divBus.clkEnable && clkPh_r;
			clkOutN <= divBus.clkEnable && !clkPh_r;
			wordClkOut <= wordClkIn ^ (ddcMode && regRand_r[rate_ctl_pkg::BIT_WCK_POL]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calibration start delay: setting times a fixed step, or immediate when disabled
	logic [15:0] dlyCnt_r;
	logic waiting_r;
	wire logic calEn = regRand_r[rate_ctl_pkg::BIT_CAL_EN];
	wire logic [15:0] dlyTarget = 16'(regDly_r) * 16'(rate_ctl_pkg::CAL_STEP_CYC);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dlyCnt_r <= 16'h0000;
			waiting_r <= 1'b0;
			calStart <= 1'b0;
		end else begin
			calStart <= 1'b0;
			if (calRequest && !waiting_r) begin
				waiting_r <= calEn;
				calStart <= !calEn;
				dlyCnt_r <= 16'h0000;
			end else if (waiting_r) begin
				dlyCnt_r <= dlyCnt_r + 16'h0001;
				if (dlyCnt_r >= dlyTarget) begin
					waiting_r <= 1'b0;
					calStart <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence calWait_s;
		calRequest && !waiting_r && calEn && (regDly_r != 8'h00);
	endsequence
	clk_stopped_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(divBus.indEnable && regRate_r[3:0] inside {[4'ha:4'he]}) [*2] |=> !clkOutP && !clkOutN)
		else $error("output clock runs in a stop code");
	clk_dep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!divBus.indEnable |-> divBus.clkEnable)
		else $error("clock field applied while dependent");
	rand_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		divBus.dataStrobe && !randEn |=> dataOut == $past(adcData))
		else $error("data altered with randomizer off");
	rand_on_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		divBus.dataStrobe && randEn && adcData[0] |=> dataOut != $past(adcData))
		else $error("data not randomized");
	wck_pol_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		1'b1 |=> wordClkOut == ($past(wordClkIn) ^ ($past(ddcMode) && $past(regRand_r[7]))))
		else $error("word clock polarity wrong");
	cal_nodly_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		calRequest && !waiting_r && !calEn |=> calStart)
		else $error("disabled delay did not start at once");
	cal_wait_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		calWait_s |=> !calStart [*2])
		else $error("calibration started without delay");
	reg_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wrDone && regAddr == rate_ctl_pkg::OFS_RATE[6:0] |=> regRate_r == $past(dataNxt))
		else $error("rate write not applied");
	sdo_edge_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$changed(spiSdo) && spiSdoOe |-> $past(sdoEdgeFall ? fall : rise))
		else $error("serial out changed on wrong edge");
	ind_en_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		divBus.indEnable == regIndRate_r[7])
		else $error("independence bit not applied");
endmodule : rate_misc_ctl
`default_nettype wire

// ==== pkg/rate_ctl_pkg.sv ====
// Register map, reset values and codes of the output rate and misc control bank
package rate_ctl_pkg;
	localparam logic [7:0] OFS_DIV_IND = 8'h01;
	localparam logic [7:0] OFS_RATE = 8'h02;
	localparam logic [7:0] OFS_SERIAL_OUT_EDGE_SELECT = 8'h04;
	localparam logic [7:0] OFS_RAND_WCK = 8'h07;
	localparam logic [7:0] OFS_CAL_DLY = 8'h1e;
	localparam logic [7:0] RST_DIV_IND = 8'h0f;
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_SERIAL_OUT_EDGE_SELECT = 8'h9f;
	localparam logic [7:0] RST_RAND_WCK = 8'h62;
	localparam logic [7:0] RST_CAL_DLY = 8'h80;
	localparam int BIT_IND_EN = 7;
	localparam int BIT_SDO_EDGE = 7;
	localparam int BIT_WCK_POL = 7;
	localparam int BIT_CAL_EN = 6;
	localparam int BIT_RAND_EN = 0;
	localparam logic [3:0] CLK_OFF_HI = 4'he;
	localparam logic [3:0] CLK_OFF_LO = 4'ha;
	// Delay counter ticks per step of the delay setting
	localparam int CAL_STEP_CYC = 16;
	localparam logic [7:0] SPI_READ = 8'h80;
endpackage : rate_ctl_pkg

// ==== pkg/rate_div_if.sv ====
// Divider settings passed from the register bank to the rate divider
`timescale 1ns/1ns
`default_nettype none
interface rate_div_if;
	logic [3:0] dataRate;
	logic [3:0] clkRate;
	logic indEnable;
	logic dataStrobe;
	logic clkToggle;
	logic clkEnable;
	modport ctl (output dataRate, output clkRate, output indEnable,
		input dataStrobe, input clkToggle, input clkEnable);
	modport div (input dataRate, input clkRate, input indEnable,
		output dataStrobe, output clkToggle, output clkEnable);
endinterface : rate_div_if
`default_nettype wire
